// *** core/nvsram_host_pkg.sv ***
// Package for the nonvolatile SRAM host controller: pin widths, sequence
// addresses, timing figures and request/pin structs.
// Assumes a 125 MHz core clock.
package nvsram_host_pkg;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int MEM_BYTES = 8192;
   localparam int CLK_PERIOD_PS = 8000;
   // Sequence addresses
   localparam logic [12:0] SEQ_A0 = 13'h0000;
   localparam logic [12:0] SEQ_A1 = 13'h1555;
   localparam logic [12:0] SEQ_A2 = 13'h0aaa;
   localparam logic [12:0] SEQ_A3 = 13'h1fff;
   localparam logic [12:0] SEQ_A4 = 13'h10f0;
   localparam logic [12:0] SEQ_SAVE = 13'h0f0f;
   localparam logic [12:0] SEQ_LOAD = 13'h0f0e;
   // Timing figures in their own units
   localparam int T_CYCLE_NS = 45;
   localparam int T_PULSE_NS = 30;
   localparam int T_ACCESS_NS = 45;
   localparam int T_RELEASE_NS = 15;
   localparam int T_SAVE_MS = 10;
   localparam int T_LOAD_US = 20;
   localparam int T_RESTORE_US = 550;
   // Least times round up to whole cycles
   localparam int PULSE_CYC = (T_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ACCESS_CYC = (T_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RECOV_CYC = ((T_CYCLE_NS - T_PULSE_NS) * 1000 + CLK_PERIOD_PS - 1)
                              / CLK_PERIOD_PS + 1;
   localparam int RELEASE_CYC = (T_RELEASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SAVE_CYC_DEF = T_SAVE_MS * 125000;
   localparam int LOAD_CYC_DEF = T_LOAD_US * 125;
   localparam int RESTORE_CYC_DEF = T_RESTORE_US * 125;
   localparam int CNT_W = 24;

   typedef enum logic [1:0] {
      OP_READ  = 2'h0,
      OP_WRITE = 2'h1,
      OP_SAVE  = 2'h2,
      OP_LOAD  = 2'h3
   } op_e;

   typedef struct packed {
      op_e                op;
      logic [ADDR_W-1:0]  addr;
      logic [DATA_W-1:0]  wdata;
   } req_s;

   typedef struct packed {
      logic               chip_en_n;
      logic               write_n;
      logic               out_gate_n;
      logic [ADDR_W-1:0]  byte_address_lines;
   } pins_s;
endpackage

// *** core/nvsram_host.sv ***
// Host controller driving an 8K x 8 nonvolatile SRAM over its pins.
// Assumes the device pins are wired straight to this block; data lines are
// split into in/out/enable and resolved outside.
// Functional notes
// - Host holds address stable through write
// - Host keeps strobes high at power-up
// - Save after six reads, ending 0F0F
// - Load after same five, then 0F0E
// - Host uses enable-clocked reads, strobe high
`timescale 1ns/100ps
`default_nettype none
module nvsram_host
   import nvsram_host_pkg::*;
#(
   parameter int SAVE_CYC    = SAVE_CYC_DEF,
   parameter int LOAD_CYC    = LOAD_CYC_DEF,
   parameter int RESTORE_CYC = RESTORE_CYC_DEF
) (
   input  wire logic              core_clk_in,
   input  wire logic              arst_n_in,
   input  wire logic              req_valid_in,
   input  wire req_s              req_in,
   output logic                   req_ready_out,
   output logic                   rsp_valid_out,
   output logic [DATA_W-1:0]      rsp_data_out,
   input  wire logic              power_good_in,
   output pins_s                  pins_out,
   input  wire logic [DATA_W-1:0] io_byte_lines_in,
   output logic [DATA_W-1:0]      io_byte_lines_out,
   output logic                   io_byte_lines_oe_out
);

   // ==========================================================
   // State
   // ==========================================================
   typedef enum logic [6:0] {
      ST_PWRUP = 7'b0000001,
      ST_IDLE  = 7'b0000010,
      ST_PULSE = 7'b0000100,
      ST_RECOV = 7'b0001000,
      ST_SEQ   = 7'b0010000,
      ST_BUSY  = 7'b0100000,
      ST_LOW   = 7'b1000000
   } state_e;

   state_e                 state_r;
   logic [CNT_W-1:0]       cnt_r;
   logic [2:0]             step_r;
   logic                   seq_mode_r;
   req_s                   cur_r;
   pins_s                  pins_r;
   logic [DATA_W-1:0]      wdata_r;
   logic                   oe_r;
   logic                   rsp_valid_r;
   logic [DATA_W-1:0]      rsp_data_r;
   logic [DATA_W-1:0]      io_meta_r;
   logic [DATA_W-1:0]      io_sync_r;
   logic [1:0]             pg_sync_r;
   logic [ADDR_W-1:0]      seq_addr;

   // ==========================================================
   // Pin input synchronisers
   // ==========================================================
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         io_meta_r <= '0;
         io_sync_r <= '0;
         pg_sync_r <= '0;
      end else begin
         io_meta_r <= io_byte_lines_in;
         io_sync_r <= io_meta_r;
         pg_sync_r <= {pg_sync_r[0], power_good_in};
      end
   end

   // Address of each sequence step; step 5 depends on save or load
   always_comb begin
      unique case (step_r)
         3'h0:    seq_addr = SEQ_A0;
         3'h1:    seq_addr = SEQ_A1;
         3'h2:    seq_addr = SEQ_A2;
         3'h3:    seq_addr = SEQ_A3;
         3'h4:    seq_addr = SEQ_A4;
         default: seq_addr = seq_mode_r ? SEQ_LOAD : SEQ_SAVE;
      endcase
   end

   // Accept only while idle and powered; every request is held back while low
   assign req_ready_out = (state_r == ST_IDLE) && pg_sync_r[1];

   // ==========================================================
   // Sequencer
   // ==========================================================
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_r     <= ST_PWRUP;
         cnt_r       <= '0;
         step_r      <= '0;
         seq_mode_r  <= 1'b0;
         cur_r       <= '0;
         pins_r      <= '{chip_en_n: 1'b1, write_n: 1'b1, out_gate_n: 1'b1,
                          byte_address_lines: '0};
         wdata_r     <= '0;
         oe_r        <= 1'b0;
         rsp_valid_r <= 1'b0;
         rsp_data_r  <= '0;
      end else begin
         rsp_valid_r <= 1'b0;
         unique case (state_r)
            // Wait out the power-up load with all strobes high
            ST_PWRUP: begin
               pins_r.chip_en_n <= 1'b1;
               pins_r.write_n   <= 1'b1;
               if (!pg_sync_r[1]) begin
                  cnt_r <= '0;
               end else if (cnt_r >= CNT_W'(RESTORE_CYC - 1)) begin
                  cnt_r   <= '0;
                  state_r <= ST_IDLE;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            ST_IDLE: begin
               if (!pg_sync_r[1]) begin
                  state_r <= ST_LOW;
               end else if (req_valid_in) begin
                  cur_r <= req_in;
                  cnt_r <= '0;
                  // Writes start with address set up, strobe low, gate high
                  pins_r.byte_address_lines <= req_in.addr;
                  wdata_r <= req_in.wdata;
                  unique case (req_in.op)
                     OP_READ: begin
                        pins_r.chip_en_n  <= 1'b0;
                        pins_r.out_gate_n <= 1'b0;
                        state_r           <= ST_PULSE;
                     end
                     OP_WRITE: begin
                        pins_r.chip_en_n  <= 1'b0;
                        pins_r.write_n    <= 1'b0;
                        pins_r.out_gate_n <= 1'b1;
                        oe_r              <= 1'b1;
                        state_r           <= ST_PULSE;
                     end
                     OP_SAVE, OP_LOAD: begin
                        seq_mode_r <= (req_in.op == OP_LOAD);
                        step_r     <= '0;
                        pins_r.byte_address_lines <= SEQ_A0;
                        state_r    <= ST_SEQ;
                     end
                  endcase
               end
            end
            // One enable pulse; address held stable throughout
            ST_PULSE: begin
               if (cnt_r >= CNT_W'((cur_r.op == OP_READ ? ACCESS_CYC : PULSE_CYC) - 1)) begin
                  cnt_r              <= '0;
                  pins_r.chip_en_n   <= 1'b1;
                  pins_r.write_n     <= 1'b1;
                  pins_r.out_gate_n  <= 1'b1;
                  if (cur_r.op == OP_READ) begin
                     rsp_data_r  <= io_sync_r;
                     rsp_valid_r <= 1'b1;
                  end
                  state_r <= ST_RECOV;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            // Data held three edges past strobe rise, then released
            ST_RECOV: begin
               if (cnt_r >= CNT_W'(RECOV_CYC - 1)) begin
                  cnt_r <= '0;
                  oe_r  <= 1'b0;
                  if (cur_r.op == OP_READ || cur_r.op == OP_WRITE) begin
                     state_r <= ST_IDLE;
                  end else if (step_r == 3'h5) begin
                     state_r <= ST_BUSY;
                  end else begin
                     step_r <= step_r + 1'b1;
                     pins_r.byte_address_lines <= (step_r == 3'h4)
                        ? (seq_mode_r ? SEQ_LOAD : SEQ_SAVE) : SEQ_A0;
                     state_r <= ST_SEQ;
                  end
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            // Enable-clocked read with gate high, strobe high; no other access between
            ST_SEQ: begin
               cur_r.op                  <= seq_mode_r ? OP_LOAD : OP_SAVE;
               pins_r.byte_address_lines <= seq_addr;
               pins_r.write_n            <= 1'b1;
               pins_r.out_gate_n         <= 1'b1;
               pins_r.chip_en_n          <= 1'b0;
               cnt_r                     <= '0;
               state_r                   <= ST_PULSE;
            end
            // Device deaf during the nonvolatile cycle
            ST_BUSY: begin
               if (cnt_r >= CNT_W'((seq_mode_r ? LOAD_CYC : SAVE_CYC) - 1)) begin
                  cnt_r   <= '0;
                  step_r  <= '0;
                  state_r <= ST_IDLE;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            // Supply low: device saves on its own, reloads on return
            ST_LOW: begin
               pins_r.chip_en_n <= 1'b1;
               pins_r.write_n   <= 1'b1;
               cnt_r            <= '0;
               state_r          <= ST_PWRUP;
            end
            default: state_r <= ST_PWRUP;
         endcase
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign pins_out             = pins_r;
   assign io_byte_lines_out    = wdata_r;
   assign io_byte_lines_oe_out = oe_r;
   assign rsp_valid_out        = rsp_valid_r;
   assign rsp_data_out         = rsp_data_r;

endmodule // nvsram_host
`default_nettype wire

// *** dv/nvsram_host_sva.sv ***
// Checker for the nonvolatile SRAM host controller pins.
// Assumes it is bound onto nvsram_host and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module nvsram_host_sva
   import nvsram_host_pkg::*;
(
   input wire logic              core_clk_in,
   input wire logic              arst_n_in,
   input wire logic              req_valid_in,
   input wire req_s              req_in,
   input wire logic              req_ready_out,
   input wire logic              rsp_valid_out,
   input wire logic [DATA_W-1:0] rsp_data_out,
   input wire logic              power_good_in,
   input wire pins_s             pins_out,
   input wire logic [DATA_W-1:0] io_byte_lines_in,
   input wire logic [DATA_W-1:0] io_byte_lines_out,
   input wire logic              io_byte_lines_oe_out
);
   // ====
   // Pin protocol
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);
   wire logic wr = !pins_out.chip_en_n && !pins_out.write_n;
   gate_in_write_a: assert property (wr |-> pins_out.out_gate_n)
      else $error("gate low during write");
   addr_hold_a: assert property (wr && $past(wr) |-> $stable(pins_out.byte_address_lines))
      else $error("address moved in write");
   data_drive_a: assert property (wr |-> io_byte_lines_oe_out)
      else $error("data not driven in write");
   bus_release_a: assert property (!pins_out.out_gate_n |-> !io_byte_lines_oe_out)
      else $error("host drives while gate low");
   pulse_width_a: assert property ($fell(pins_out.chip_en_n) |-> !pins_out.chip_en_n [*4])
      else $error("enable pulse short");
   read_answer_a: assert property ($rose(pins_out.chip_en_n) && !$past(pins_out.out_gate_n)
      |-> ##[0:1] rsp_valid_out)
      else $error("no read answer");
   take_busy_a: assert property (req_valid_in && req_ready_out |=> !req_ready_out)
      else $error("ready after take");
   power_low_a: assert property (!power_good_in [*3] |-> !req_ready_out)
      else $error("ready while power low");
endmodule // nvsram_host_sva
bind nvsram_host nvsram_host_sva u_sva (.core_clk_in, .arst_n_in, .req_valid_in, .req_in,
   .req_ready_out, .rsp_valid_out, .rsp_data_out, .power_good_in, .pins_out,
   .io_byte_lines_in, .io_byte_lines_out, .io_byte_lines_oe_out);
`default_nettype wire

// *** dv/nvsram_dev_model.sv ***
// Behavioural model of the 8K x 8 nonvolatile SRAM.
// Assumes the bench resolves the shared data lines from both enables.
`timescale 1ns/100ps
`default_nettype none
module nvsram_dev_model
   import nvsram_host_pkg::*;
#(
   parameter int SAVE_NS = 300,
   parameter int LOAD_NS = 100
) (
   input  wire logic              power_good_in,
   input  wire pins_s             pins_in,
   input  wire logic [DATA_W-1:0] io_byte_lines_in,
   output logic [DATA_W-1:0]      io_byte_lines_out,
   output logic                   io_byte_lines_oe_out
);
   logic [DATA_W-1:0] mem [MEM_BYTES];
   logic [DATA_W-1:0] nv [MEM_BYTES];
   logic              busy = 1'b1;
   logic              dirty = 1'b0;
   logic              hit;
   logic [12:0]       a;
   int                step = 0;
   logic [12:0]       seq5 [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
   wire logic wr = !busy && power_good_in && !pins_in.chip_en_n && !pins_in.write_n;
   // Sixth sequence read leaves the data lines floating
   assign io_byte_lines_oe_out = !busy && !pins_in.chip_en_n && !pins_in.out_gate_n
      && pins_in.write_n && !(step == 5 && pins_in.byte_address_lines[12:1] == 12'h787);
   assign io_byte_lines_out = mem[pins_in.byte_address_lines];
   initial foreach (mem[i]) begin
      mem[i] = 8'hff;
      nv[i] = 8'h00;
   end
   task automatic save();
      busy = 1'b1;
      foreach (nv[i]) nv[i] = 8'hff;
      #(SAVE_NS);
      nv = mem;
      dirty = 1'b0;
      busy = 1'b0;
   endtask
   task automatic load();
      busy = 1'b1;
      foreach (mem[i]) mem[i] = 8'h00;
      #(LOAD_NS);
      mem = nv;
      dirty = 1'b0;
      busy = 1'b0;
   endtask
   always @(negedge wr) begin
      mem[pins_in.byte_address_lines] = io_byte_lines_in;
      dirty = 1'b1;
      step = 0;
   end
   always @(posedge pins_in.chip_en_n) begin
      if (pins_in.write_n && !busy) begin
         a = pins_in.byte_address_lines;
         hit = (step == 5);
         step = (step < 5 && a == seq5[step]) ? step + 1 : int'(a == SEQ_A0);
         if (hit && a == SEQ_SAVE && power_good_in) save();
         else if (hit && a == SEQ_LOAD) load();
      end
   end
   always @(negedge power_good_in) if (dirty) save();
   always @(posedge power_good_in) load();
endmodule // nvsram_dev_model
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the nonvolatile SRAM host controller.
// Assumes the device model and the bound pin checker.
`timescale 1ns/100ps
`default_nettype none
module tb
   import nvsram_host_pkg::*;
;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic              req_valid = 1'b0;
   logic              pg = 1'b0;
   req_s              req = '0;
   logic              req_ready, rsp_valid, host_oe, dev_oe;
   logic [DATA_W-1:0] rsp_data, host_q, dev_q;
   logic [DATA_W-1:0] float_q = 8'h5a;
   pins_s             pins;
   logic [DATA_W-1:0] exp [MEM_BYTES];
   logic [DATA_W-1:0] nv_exp [MEM_BYTES];
   logic [12:0]       seq5 [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
   logic [12:0]       a;
   int                err_total = 0;
   int                checks = 0;
   int                seed = 32'h036a1529;
   // Cycles to sit out a save or load started by raw reads; the host cannot see it
   localparam int     SAVE_WAIT = 50;
   localparam int     LOAD_WAIT = 20;
   wire logic [DATA_W-1:0] bus = host_oe ? host_q : dev_oe ? dev_q : float_q;
   always #4 clk = ~clk;
   always @(posedge clk) float_q <= ~float_q;
   nvsram_host #(.SAVE_CYC(50), .LOAD_CYC(20), .RESTORE_CYC(30)) u_dut (.core_clk_in(clk),
      .arst_n_in(rst_n), .req_valid_in(req_valid), .req_in(req), .req_ready_out(req_ready),
      .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .power_good_in(pg), .pins_out(pins),
      .io_byte_lines_in(bus), .io_byte_lines_out(host_q), .io_byte_lines_oe_out(host_oe));
   nvsram_dev_model u_dev (.power_good_in(pg), .pins_in(pins), .io_byte_lines_in(bus),
      .io_byte_lines_out(dev_q), .io_byte_lines_oe_out(dev_oe));
   // ====
   // Tasks
   task automatic results();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic fail(input string m);
      err_total++;
      $display("MISMATCH %0t %s", $time, m);
   endtask
   function automatic logic [7:0] exp_byte(input logic [12:0] ad);
      return exp[ad];
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      checks++;
      if (got !== want) fail("read data");
   endtask
   task automatic op(input op_e o, input logic [12:0] ad, input logic [7:0] d);
      int n;
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{o, ad, d};
      n = 0;
      do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 3000);
      req_valid <= 1'b0;
      if (n >= 3000) begin fail("ready timeout"); results(); end
      if (o == OP_READ) begin
         n = 0;
         do begin @(posedge clk); n++; end while (rsp_valid !== 1'b1 && n < 40);
         if (n >= 40) begin fail("read timeout"); results(); end
         // Sixth sequence read floats, so its byte is not compared
         if (ad[12:1] != 12'h787) chk(rsp_data, exp_byte(ad));
      end
      else if (o == OP_WRITE) exp[ad] = d;
      else if (o == OP_SAVE) nv_exp = exp;
      else exp = nv_exp;
   endtask
   task automatic rd_seq(input int from, input int to);
      for (int k = from; k < to; k++) op(OP_READ, seq5[k], 8'h00);
   endtask
   // ====
   // Scenarios
   initial begin
      foreach (exp[i]) begin exp[i] = 8'h00; nv_exp[i] = 8'h00; end
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      pg <= 1'b1;
      for (int i = 0; i < 24; i++) begin
         a = (i < 2) ? {13{i[0]}} : 13'($random(seed));
         op(OP_WRITE, a, 8'($random(seed)));
         op(OP_READ, a, 8'h00);
         op(OP_READ, 13'($random(seed)), 8'h00);
      end
      $display("test rw done");
      op(OP_WRITE, 13'h0123, 8'h11);
      op(OP_SAVE, 13'h0000, 8'h00);
      op(OP_WRITE, 13'h0123, 8'h22);
      rd_seq(0, 4);
      op(OP_WRITE, 13'h0123, 8'h33);
      rd_seq(4, 5);
      op(OP_READ, SEQ_SAVE, 8'h00);
      op(OP_LOAD, 13'h0000, 8'h00);
      op(OP_LOAD, 13'h0000, 8'h00);
      op(OP_READ, 13'h0123, 8'h00);
      $display("test abort done");
      op(OP_WRITE, 13'h0123, 8'h44);
      rd_seq(0, 3);
      rd_seq(0, 5);
      op(OP_READ, SEQ_SAVE, 8'h00);
      nv_exp = exp;
      repeat (SAVE_WAIT) @(posedge clk);
      op(OP_WRITE, 13'h0123, 8'h66);
      rd_seq(0, 5);
      op(OP_READ, SEQ_LOAD, 8'h00);
      exp = nv_exp;
      repeat (LOAD_WAIT) @(posedge clk);
      op(OP_READ, 13'h0123, 8'h00);
      $display("test sequence done");
      op(OP_WRITE, 13'h0123, 8'h77);
      // Write must end before supply drops, or the save races the store
      repeat (8) @(posedge clk);
      pg <= 1'b0;
      repeat (60) @(posedge clk);
      pg <= 1'b1;
      nv_exp = exp;
      op(OP_READ, 13'h0123, 8'h00);
      $display("test power done");
      results();
   end
endmodule // tb
`default_nettype wire
